// [rtl/core_clock_power_modes.sv]
`timescale 1ns/100ps
// What this block does
// - Prescale codes divide by 1..32, 1024, 2048
// - Prescaler resets to zero, full speed
// - Debug comparator enable resets high, writable
// - Interrupt with auto bit forces prescale zero
// - New prescale value applies immediately
// - Peripheral clock never divided by prescaler
// - Idle gates the core and watchdog clocks
// - Idle keeps peripherals, resets alive; watchdog stopped
// - Idle exits on interrupt or supervisor reset
// - Port outputs hold during idle
// - Idle-setting instruction is the last executed
// - Core state preserved while idle
// - Enabled interrupt clears idle request bit
// - Resume after instruction that set idle
// - Supervisor reset clears idle, restart after three cycles
// - Power-down gates core and peripheral clocks
// - Power-down instruction is the last executed
// - Power-down stops oscillator, retains state
// - Only supervisor resets end power-down
// - No watchdog reset during power-down
module core_clock_power_modes
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_control_write,
	input wire logic [7:0] clock_control_wdata,
	output logic [7:0] clock_control_rdata,
	input wire logic power_control_write,
	input wire logic [7:0] power_control_wdata,
	output logic [7:0] power_control_rdata,
	input wire logic core_interrupt,
	input wire logic supervisor_reset,
	input wire logic supervisor_reset_from_watchdog,
	output logic core_clock_enable,
	output logic watchdog_clock_enable,
	output logic peripheral_clock_enable,
	output logic oscillator_enable,
	output logic port_output_hold,
	output logic core_state_hold,
	output logic debug_compare_enable,
	output logic core_restart_hold,
	output logic [1:0] power_mode
);
	logic [2:0] prescale_ff;
	logic [2:0] nxt_prescale;
	logic auto_full_speed_on_irq_ff;
	logic nxt_auto_full_speed;
	logic debug_compare_ff;
	logic nxt_debug_compare;
	logic idle_request_bit_ff;
	logic nxt_idle_request_bit;
	logic powerdown_request_bit_ff;
	logic nxt_powerdown_request_bit;
	logic [7:0] power_control_reg_other_ff;
	logic [7:0] nxt_power_control_reg_other;
	clk_power_pkg::power_mode_t mode_ff;
	clk_power_pkg::power_mode_t nxt_mode;
	logic [3:0] restart_count_ff;
	logic [3:0] nxt_restart_count;
	logic core_tick;
	logic running;
	logic accepted_reset;

	localparam logic [3:0] RESTART_TICKS = 4'(clk_power_pkg::RESTART_MACHINE_CYCLES
		* clk_power_pkg::CLOCKS_PER_MACHINE_CYCLE);

	// Every clock stops, oscillator included
	function automatic logic clocks_stopped(input clk_power_pkg::power_mode_t m);
		clocks_stopped = (m == clk_power_pkg::MODE_POWERDOWN);
	endfunction

	// Either low-power state freezes the core and its pins
	function automatic logic low_power(input clk_power_pkg::power_mode_t m);
		low_power = (m == clk_power_pkg::MODE_IDLE)
			|| (m == clk_power_pkg::MODE_POWERDOWN);
	endfunction

	// Watchdog is already stopped in power-down; ignore its reset there too
	assign accepted_reset = supervisor_reset
		&& !(clocks_stopped(mode_ff)
		&& supervisor_reset_from_watchdog);

	// Register state group
	always_comb
	begin
		nxt_prescale = prescale_ff;
		nxt_auto_full_speed = auto_full_speed_on_irq_ff;
		nxt_debug_compare = debug_compare_ff;
		if (clock_control_write)
		begin
			nxt_prescale = clock_control_wdata[clk_power_pkg::PRESCALE_MSB:
				clk_power_pkg::PRESCALE_LSB];
			nxt_auto_full_speed = clock_control_wdata[clk_power_pkg::AUTO_FULL_SPEED_BIT];
			nxt_debug_compare = clock_control_wdata[clk_power_pkg::DEBUG_COMPARE_BIT];
		end
		// Interrupt wins over a same-cycle write that sets the auto bit, to restore full speed
		if (core_interrupt && nxt_auto_full_speed)
		begin
			nxt_prescale = clk_power_pkg::PRESCALE_FULL_SPEED;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			prescale_ff <= clk_power_pkg::CLOCK_CONTROL_RESET[2:0];
			auto_full_speed_on_irq_ff <= clk_power_pkg::CLOCK_CONTROL_RESET[3];
			debug_compare_ff <= clk_power_pkg::CLOCK_CONTROL_RESET[4];
		end
		else
		begin
			prescale_ff <= nxt_prescale;
			auto_full_speed_on_irq_ff <= nxt_auto_full_speed;
			debug_compare_ff <= nxt_debug_compare;
		end
	end

	// Power mode group
	always_comb
	begin
		nxt_idle_request_bit = idle_request_bit_ff;
		nxt_powerdown_request_bit = powerdown_request_bit_ff;
		nxt_power_control_reg_other = power_control_reg_other_ff;
		nxt_mode = mode_ff;
		nxt_restart_count = restart_count_ff;
		unique case (mode_ff)
			clk_power_pkg::MODE_RUN:
			begin
				if (power_control_write)
				begin
					nxt_power_control_reg_other = power_control_wdata & 8'hfc;
					nxt_idle_request_bit =
						power_control_wdata[clk_power_pkg::IDLE_REQUEST_POS];
					nxt_powerdown_request_bit =
						power_control_wdata[clk_power_pkg::POWERDOWN_REQUEST_POS];
					// Mode changes on the write itself: no further instruction
					if (nxt_powerdown_request_bit)
					begin
						nxt_mode = clk_power_pkg::MODE_POWERDOWN;
					end
					else if (nxt_idle_request_bit)
					begin
						nxt_mode = clk_power_pkg::MODE_IDLE;
					end
				end
			end
			clk_power_pkg::MODE_IDLE:
			begin
				if (accepted_reset)
				begin
					nxt_idle_request_bit = 1'b0;
					nxt_restart_count = RESTART_TICKS;
					nxt_mode = clk_power_pkg::MODE_RESTART;
				end
				else if (core_interrupt)
				begin
					// Core resumes at the next instruction; its PC was frozen
					nxt_idle_request_bit = 1'b0;
					nxt_mode = clk_power_pkg::MODE_RUN;
				end
			end
			clk_power_pkg::MODE_POWERDOWN:
			begin
				if (accepted_reset)
				begin
					nxt_idle_request_bit = 1'b0;
					nxt_powerdown_request_bit = 1'b0;
					nxt_restart_count = RESTART_TICKS;
					nxt_mode = clk_power_pkg::MODE_RESTART;
				end
			end
			clk_power_pkg::MODE_RESTART:
			begin
				if (restart_count_ff == 4'h1)
				begin
					nxt_mode = clk_power_pkg::MODE_RUN;
				end
				nxt_restart_count = restart_count_ff - 4'h1;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			idle_request_bit_ff <= 1'b0;
			powerdown_request_bit_ff <= 1'b0;
			power_control_reg_other_ff <= clk_power_pkg::POWER_CONTROL_RESET;
			mode_ff <= clk_power_pkg::MODE_RUN;
			restart_count_ff <= 4'h0;
		end
		else
		begin
			idle_request_bit_ff <= nxt_idle_request_bit;
			powerdown_request_bit_ff <= nxt_powerdown_request_bit;
			power_control_reg_other_ff <= nxt_power_control_reg_other;
			mode_ff <= nxt_mode;
			restart_count_ff <= nxt_restart_count;
		end
	end

	assign running = (mode_ff == clk_power_pkg::MODE_RUN);

	core_clock_divider divider
	(
		.clock(clock),
		.reset_n(reset_n),
		.core_clock_prescale(prescale_ff),
		.run(running),
		.tick(core_tick)
	);

	assign core_clock_enable = core_tick;
	assign watchdog_clock_enable = core_tick;
	// Peripheral clock never sees the prescaler
	assign peripheral_clock_enable = !clocks_stopped(mode_ff);
	assign oscillator_enable = !clocks_stopped(mode_ff);
	assign port_output_hold = low_power(mode_ff);
	assign core_state_hold = !running;
	assign core_restart_hold = (mode_ff == clk_power_pkg::MODE_RESTART);
	assign debug_compare_enable = debug_compare_ff;
	assign power_mode = mode_ff;
	// Reserved bits read zero
	assign clock_control_rdata = {3'h0, debug_compare_ff, auto_full_speed_on_irq_ff,
		prescale_ff};
	assign power_control_rdata = {power_control_reg_other_ff[7:2], powerdown_request_bit_ff,
		idle_request_bit_ff};
endmodule

// [rtl/clk_power_pkg.sv]
package clk_power_pkg;
	// Clock control register layout
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h10;
	localparam int PRESCALE_LSB = 0;
	localparam int PRESCALE_MSB = 2;
	localparam int AUTO_FULL_SPEED_BIT = 3;
	localparam int DEBUG_COMPARE_BIT = 4;
	localparam logic [7:0] CLOCK_CONTROL_WRITE_MASK = 8'h1f;
	// Power control register bits handled here
	localparam int IDLE_REQUEST_POS = 0;
	localparam int POWERDOWN_REQUEST_POS = 1;
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	// Restart delay after supervisor reset, in core machine cycles
	localparam int RESTART_MACHINE_CYCLES = 3;
	localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
	localparam int DIVIDER_WIDTH = 11;
	localparam logic [2:0] PRESCALE_FULL_SPEED = 3'h0;

	typedef enum logic [1:0]
	{
		MODE_RUN = 2'b00,
		MODE_IDLE = 2'b01,
		MODE_POWERDOWN = 2'b10,
		MODE_RESTART = 2'b11
	} power_mode_t;
endpackage

// [rtl/core_clock_divider.sv]
`timescale 1ns/100ps
module core_clock_divider
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] core_clock_prescale,
	input wire logic run,
	output logic tick
);
	logic [clk_power_pkg::DIVIDER_WIDTH-1:0] count_ff;
	logic [clk_power_pkg::DIVIDER_WIDTH-1:0] nxt_count;
	logic [clk_power_pkg::DIVIDER_WIDTH-1:0] limit;
	logic nxt_tick;
	logic tick_ff;

	function automatic logic [clk_power_pkg::DIVIDER_WIDTH-1:0] divide_limit(
		input logic [2:0] code);
		unique case (code)
			3'h0: divide_limit = 11'h000;
			3'h1: divide_limit = 11'h001;
			3'h2: divide_limit = 11'h003;
			3'h3: divide_limit = 11'h007;
			3'h4: divide_limit = 11'h00f;
			3'h5: divide_limit = 11'h01f;
			3'h6: divide_limit = 11'h3ff;
			3'h7: divide_limit = 11'h7ff;
		endcase
	endfunction

	always_comb
	begin
		limit = divide_limit(core_clock_prescale);
		nxt_count = count_ff;
		nxt_tick = 1'b0;
		if (run)
		begin
			// Compare with >= so a new smaller divisor applies at once
			if (count_ff >= limit)
			begin
				nxt_count = '0;
				nxt_tick = 1'b1;
			end
			else
			begin
				nxt_count = count_ff + 11'h001;
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			count_ff <= '0;
			tick_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			tick_ff <= nxt_tick;
		end
	end

	// Divide-by-one must tick every cycle, so the enable is combinational
	assign tick = run && (limit == 11'h000 ? 1'b1 : tick_ff);
endmodule

// [dv/core_clock_power_modes_checker.sv]
`timescale 1ns/100ps
module core_clock_power_modes_checker
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_control_write,
	input wire logic [7:0] clock_control_wdata,
	input wire logic [7:0] clock_control_rdata,
	input wire logic power_control_write,
	input wire logic [7:0] power_control_wdata,
	input wire logic [7:0] power_control_rdata,
	input wire logic core_interrupt,
	input wire logic supervisor_reset,
	input wire logic supervisor_reset_from_watchdog,
	input wire logic core_clock_enable,
	input wire logic watchdog_clock_enable,
	input wire logic peripheral_clock_enable,
	input wire logic oscillator_enable,
	input wire logic port_output_hold,
	input wire logic core_state_hold,
	input wire logic debug_compare_enable,
	input wire logic core_restart_hold,
	input wire logic [1:0] power_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	wire in_run = power_mode == clk_power_pkg::MODE_RUN;
	wire in_idle = power_mode == clk_power_pkg::MODE_IDLE;
	wire in_pd = power_mode == clk_power_pkg::MODE_POWERDOWN;
	wire in_rs = power_mode == clk_power_pkg::MODE_RESTART;
	wire quiet = !core_interrupt && !supervisor_reset;
	// Restart spans twelve clocks, then run
	sequence restart_seq;
		(in_rs && core_restart_hold)[*8] ##4 in_rs ##1 in_run;
	endsequence
	a_idle_gates_core: assert property (in_idle |-> !core_clock_enable && !watchdog_clock_enable && peripheral_clock_enable)
		else $error("idle clock gating wrong");
	a_pd_gates_all: assert property (in_pd |-> !core_clock_enable && !peripheral_clock_enable && !oscillator_enable)
		else $error("power-down clock gating wrong");
	a_periph_runs: assert property (!in_pd |-> peripheral_clock_enable && oscillator_enable)
		else $error("peripheral clock stopped");
	a_state_held: assert property (in_idle || in_pd |-> port_output_hold && core_state_hold)
		else $error("state not held in low power");
	a_irq_wakes_idle: assert property (in_idle && core_interrupt && !supervisor_reset |=> in_run && !power_control_rdata[0])
		else $error("interrupt did not end idle");
	a_pd_keeps_on_irq: assert property (in_pd && core_interrupt && !supervisor_reset |=> in_pd)
		else $error("interrupt woke power-down");
	a_pd_no_watchdog: assert property (in_pd && supervisor_reset && supervisor_reset_from_watchdog |=> in_pd)
		else $error("watchdog reset ended power-down");
	a_reset_restart: assert property ((in_idle || in_pd) && supervisor_reset && !supervisor_reset_from_watchdog |=> restart_seq)
		else $error("restart sequence wrong");
	a_enter_idle: assert property (in_run && quiet && power_control_write && power_control_wdata[1:0] == 2'h1 |=> in_idle)
		else $error("idle not entered");
	a_both_powerdown: assert property (in_run && quiet && power_control_write && power_control_wdata[1:0] == 2'h3 |=> in_pd)
		else $error("power-down not chosen");
	a_auto_speed: assert property (clock_control_rdata[3] && core_interrupt && !clock_control_write |=> clock_control_rdata[2:0] == 3'h0)
		else $error("auto full speed failed");
	a_write_applies: assert property (clock_control_write && !core_interrupt |=> clock_control_rdata[4:0] == $past(clock_control_wdata[4:0]) && debug_compare_enable == clock_control_rdata[4])
		else $error("clock control write lost");
	a_reserved_zero: assert property (clock_control_rdata[7:5] == 3'h0)
		else $error("reserved bits set");
endmodule
bind core_clock_power_modes core_clock_power_modes_checker chk (.*);

// [dv/core_side_model.sv]
`timescale 1ns/100ps
module core_side_model
(
	input wire logic clock,
	input wire logic core_clock_enable,
	input wire logic irq_cmd,
	input wire logic rst_cmd,
	input wire logic wdt_cmd,
	output logic core_interrupt,
	output logic supervisor_reset,
	output logic supervisor_reset_from_watchdog,
	output int ticks
);
	// Core advances one step per enable pulse
	initial ticks = 0;
	always @(posedge clock)
		if (core_clock_enable)
			ticks <= ticks + 1;
	assign core_interrupt = irq_cmd;
	// Watchdog reset still flagged so the block must drop it in power-down
	assign supervisor_reset = rst_cmd | wdt_cmd;
	assign supervisor_reset_from_watchdog = wdt_cmd;
endmodule

// [dv/core_clock_power_modes_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module core_clock_power_modes_bench;
	logic clock, reset_n, clock_control_write, power_control_write;
	logic [7:0] clock_control_wdata, clock_control_rdata, power_control_wdata, power_control_rdata;
	logic core_interrupt, supervisor_reset, supervisor_reset_from_watchdog, core_clock_enable;
	logic watchdog_clock_enable, peripheral_clock_enable, oscillator_enable, port_output_hold;
	logic core_state_hold, debug_compare_enable, core_restart_hold, irq_cmd, rst_cmd, wdt_cmd;
	logic [1:0] power_mode;
	int ticks, n_mismatch, comparisons;
	core_clock_power_modes uut (.*);
	core_side_model partner (.*);
	initial
	begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	task automatic step(int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic wr_cc(logic [7:0] d);
		clock_control_wdata = d;
		clock_control_write = 1;
		step(1);
		clock_control_write = 0;
	endtask
	task automatic wr_pc(logic [7:0] d);
		power_control_wdata = d;
		power_control_write = 1;
		step(1);
		power_control_write = 0;
	endtask
	task automatic pulse_reset(logic wdt);
		int n;
		rst_cmd = !wdt;
		wdt_cmd = wdt;
		step(1);
		rst_cmd = 0;
		wdt_cmd = 0;
		n = 0;
		// Bounded wait doubles as the hang guard
		while (!wdt && power_mode !== 2'b00 && n < 20)
		begin
			step(1);
			n++;
		end
		if (!wdt) `CHK("restart cycles", 12, n)
		if (n >= 20)
			close_out;
	endtask
	task automatic t_prescale;
		int div[8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};
		int t0;
		`CHK("clock reg reset", 8'h10, clock_control_rdata)
		`CHK("power reg reset", 8'h00, power_control_rdata)
		for (int i = 0; i < 8; i++)
		begin
			wr_cc(8'h10 | i[7:0]);
			step(2048);
			t0 = ticks;
			step(4096);
			`CHK("core ticks", 4096 / div[i], ticks - t0)
		end
		wr_cc(8'hff);
		`CHK("clock reg", 8'h1f, clock_control_rdata)
		irq_cmd = 1;
		step(1);
		irq_cmd = 0;
		`CHK("auto speed", 8'h18, clock_control_rdata)
		wr_cc(8'h07);
		`CHK("debug off", 1'b0, debug_compare_enable)
		wr_cc(8'h00);
		`CHK("full speed now", 1'b1, core_clock_enable)
		$display("prescale test done");
	endtask
	task automatic t_idle;
		wr_pc(8'hfc);
		`CHK("other power_control_reg bits", 8'hfc, power_control_rdata)
		`CHK("no mode change", 2'b00, power_mode)
		wr_pc(8'h01);
		`CHK("idle mode", 2'b01, power_mode)
		`CHK("core gated", 1'b0, core_clock_enable)
		`CHK("ports held", 1'b1, port_output_hold)
		wr_pc(8'h02);
		`CHK("write refused", 8'h01, power_control_rdata)
		irq_cmd = 1;
		step(1);
		irq_cmd = 0;
		`CHK("idle woken", 2'b00, power_mode)
		`CHK("idle bit clear", 1'b0, power_control_rdata[0])
		wr_pc(8'h01);
		pulse_reset(0);
		`CHK("idle bit reset", 1'b0, power_control_rdata[0])
		$display("idle test done");
	endtask
	task automatic t_pd;
		wr_pc(8'h03);
		`CHK("pd mode", 2'b10, power_mode)
		`CHK("periph gated", 1'b0, peripheral_clock_enable)
		`CHK("osc stopped", 1'b0, oscillator_enable)
		irq_cmd = 1;
		step(3);
		irq_cmd = 0;
		`CHK("irq ignored", 2'b10, power_mode)
		pulse_reset(1);
		`CHK("wdt ignored", 2'b10, power_mode)
		pulse_reset(0);
		`CHK("pd bit reset", 8'h00, power_control_rdata)
		`CHK("osc back", 1'b1, oscillator_enable)
		$display("power-down test done");
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		{reset_n, clock_control_write, power_control_write, irq_cmd, rst_cmd, wdt_cmd} = 0;
		clock_control_wdata = 0;
		power_control_wdata = 0;
		repeat (12) @(posedge clock);
		#2;
		reset_n = 1;
		step(1);
		t_prescale;
		t_idle;
		t_pd;
		close_out;
	end
endmodule
